// ===== hdl/acr_defs.svh
/*
  Offsets, field positions, reset values and timing counts of the converter control registers.
  Assumes inclusion by bare name from design files.
*/
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH
// ==========================================
// Register offsets
`define ACR_OFS_CMD 12'hF70
`define ACR_OFS_FMT 12'hF71
`define ACR_OFS_STATUS 12'hF7A
`define ACR_OFS_MASK 12'hF7B
// ==========================================
// Command register fields
`define ACR_CMD_START_HI 7
`define ACR_CMD_START_LO 6
`define ACR_CMD_RSVD 5
`define ACR_CMD_IRQSEL 4
`define ACR_CMD_CONT 3
`define ACR_CMD_AVE 2
`define ACR_CMD_AVECNT_HI 1
`define ACR_CMD_AVECNT_LO 0
// ==========================================
// Format register fields
`define ACR_FMT_SCAN 5
`define ACR_FMT_INKIND 3
`define ACR_FMT_SIGN 2
`define ACR_FMT_WIDTH 1
`define ACR_FMT_ALIGN 0
// ==========================================
// Reset values
`define ACR_RST_CMD 8'h00
`define ACR_RST_FMT 8'h00
`define ACR_RST_IRQ 8'h00
// ==========================================
// Status bits
`define ACR_ST_EOC 0
`define ACR_ST_WIN 1
`define ACR_ST_CAL 2
// ==========================================
// Timing counts in converter clock cycles, and the largest sample count
`define ACR_CYC_12B 5'd13
`define ACR_CYC_14B 5'd15
`define ACR_CYC_CAL 5'd16
`define ACR_SAMP_LARGE 5'd16
`endif

// ===== hdl/acr_pkg.sv
/*
  Types shared by the converter control design.
  Assumes acr_defs.svh holds all numeric constants except the command and state codes defined here.
*/
package acr_pkg;
  // Command field codes
  typedef enum logic [1:0] {
    ACR_CMD_IDLE = 2'b00,
    ACR_CMD_CONV = 2'b01,
    ACR_CMD_OFS = 2'b10,
    ACR_CMD_GAIN = 2'b11
  } acr_cmd_t;
  // Sequencer states
  typedef enum logic [1:0] {
    ACR_ST_IDLE = 2'b00,
    ACR_ST_RUN = 2'b01,
    ACR_ST_DONE = 2'b10
  } acr_state_t;
endpackage

// ===== hdl/acr_sequencer.sv
/*
  Conversion sequencer: counts converter cycles per sample and samples per result.
  Assumes one clock, asynchronous active-low reset, a one-cycle start pulse.
*/
`include "acr_defs.svh"
module acr_sequencer (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [4:0] cycles_in,
  input wire logic [4:0] samples_in,
  output logic busy_out,
  output logic done_out
);
  import acr_pkg::*;
  acr_state_t state_q, state_d;
  logic [4:0] cyc_q, cyc_d;
  logic [4:0] smp_q, smp_d;
  logic done_q, done_d;

  // Next state: run cycles for each sample, then report completion
  always_comb begin
    state_d = state_q;
    cyc_d = cyc_q;
    smp_d = smp_q;
    done_d = 1'b0;
    case (state_q)
      ACR_ST_IDLE: begin
        if (start_in) begin
          state_d = ACR_ST_RUN;
          cyc_d = 5'h01;
          smp_d = 5'h01;
        end
      end
      ACR_ST_RUN: begin
        if (abort_in) begin
          state_d = ACR_ST_IDLE;
        end else if (cyc_q >= cycles_in) begin
          cyc_d = 5'h01;
          if (smp_q >= samples_in) begin
            // Finish straight to idle so busy spans exactly cycles times samples
            state_d = ACR_ST_IDLE;
            done_d = 1'b1;
          end else begin
            smp_d = smp_q + 5'h01;
          end
        end else begin
          cyc_d = cyc_q + 5'h01;
        end
      end
      ACR_ST_DONE: begin
        done_d = 1'b1;
        state_d = ACR_ST_IDLE;
      end
      default: state_d = ACR_ST_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ACR_ST_IDLE;
      cyc_q <= 5'h00;
      smp_q <= 5'h00;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      smp_q <= smp_d;
      done_q <= done_d;
    end
  end

  assign busy_out = (state_q != ACR_ST_IDLE);
  assign done_out = done_q;
endmodule

// ===== hdl/acr_control.sv
/*
  Converter control register pair with command sequencing, result status and interrupt.
  Assumes a plain register port on clk_in; the window hit comes from the core on the same clock.
*/
// Chosen here: the plain strobed port.
//
// Contract
// - Command reads 00 when converter idle
// - Command 10 runs offset calibration
// - Command 11 runs gain calibration
// - Source bit picks window-only or also end
// - Averaging off: one conversion per result
// - Averaging on: several samples per result
// - Count codes select 2, 4, 8, larger
// - Scan bit enables channel stepping
// - Sign bit selects unsigned or two's complement
// - Width bit selects 12/13 or 14/15
`include "acr_defs.svh"
module acr_control (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic window_hit_in,
  output logic [7:0] rdata_out,
  output logic irq_out,
  output logic busy_out,
  output logic [1:0] command_out,
  output logic continuous_conversion_out,
  output logic [4:0] sample_count_out,
  output logic [4:0] cycles_out,
  output logic scan_enable_out,
  output logic input_kind_out,
  output logic result_sign_format_out,
  output logic result_alignment_out,
  output logic cal_offset_out,
  output logic cal_gain_out
);
  import acr_pkg::*;

  // ==========================================
  // Register state
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] fmt_q, fmt_d;
  logic [7:0] stat_q, stat_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic [1:0] op_q, op_d;
  logic seq_start_q, seq_start_d;
  logic seq_busy;
  logic seq_done;
  logic seq_abort;
  logic [4:0] samples;
  logic [4:0] cycles;
  logic wr_cmd, wr_fmt, wr_stat, wr_mask;
  logic [7:0] ev_set;
  logic [1:0] new_cmd;

  assign wr_cmd = wr_in && (addr_in == `ACR_OFS_CMD);
  assign wr_fmt = wr_in && (addr_in == `ACR_OFS_FMT);
  assign wr_stat = wr_in && (addr_in == `ACR_OFS_STATUS);
  assign wr_mask = wr_in && (addr_in == `ACR_OFS_MASK);
  assign new_cmd = wdata_in[`ACR_CMD_START_HI:`ACR_CMD_START_LO];

  // ==========================================
  // Sample count and conversion length
  always_comb begin
    if (!cmd_q[`ACR_CMD_AVE]) begin
      samples = 5'h01;
    end else begin
      case (cmd_q[`ACR_CMD_AVECNT_HI:`ACR_CMD_AVECNT_LO])
        2'b00: samples = 5'h02;
        2'b01: samples = 5'h04;
        2'b10: samples = 5'h08;
        default: samples = `ACR_SAMP_LARGE;
      endcase
    end
    if (op_q == ACR_CMD_OFS || op_q == ACR_CMD_GAIN) begin
      cycles = `ACR_CYC_CAL;
    end else if (fmt_q[`ACR_FMT_WIDTH]) begin
      cycles = `ACR_CYC_14B;
    end else begin
      cycles = `ACR_CYC_12B;
    end
  end

  // ==========================================
  // Conversion sequencer
  acr_sequencer u_seq (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .start_in(seq_start_q),
    .abort_in(seq_abort),
    .cycles_in(cycles),
    .samples_in(samples),
    .busy_out(seq_busy),
    .done_out(seq_done)
  );

  // Writing 00 while busy aborts the running operation
  assign seq_abort = wr_cmd && (new_cmd == ACR_CMD_IDLE) && seq_busy;

  // ==========================================
  // Command register, operation tracking and start pulse
  always_comb begin
    cmd_d = cmd_q;
    op_d = op_q;
    seq_start_d = 1'b0;
    if (wr_cmd) begin
      // Options stay writable; bit 5 is held at zero
      cmd_d[4:0] = wdata_in[4:0];
      cmd_d[`ACR_CMD_RSVD] = 1'b0;
      if (new_cmd != ACR_CMD_IDLE && op_q == ACR_CMD_IDLE) begin
        op_d = new_cmd;
        seq_start_d = 1'b1;
      end else if (new_cmd == ACR_CMD_IDLE) begin
        op_d = ACR_CMD_IDLE;
      end
    end else if (seq_done) begin
      // Continuous conversion restarts; everything else returns to idle
      if (op_q == ACR_CMD_CONV && cmd_q[`ACR_CMD_CONT]) begin
        seq_start_d = 1'b1;
      end else begin
        op_d = ACR_CMD_IDLE;
      end
    end
    cmd_d[`ACR_CMD_START_HI:`ACR_CMD_START_LO] = op_d;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_q <= `ACR_RST_CMD;
      op_q <= ACR_CMD_IDLE;
      seq_start_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      op_q <= op_d;
      seq_start_q <= seq_start_d;
    end
  end

  // ==========================================
  // Format register: every bit stored as written
  always_comb begin
    fmt_d = fmt_q;
    if (wr_fmt) begin
      fmt_d = wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fmt_q <= `ACR_RST_FMT;
    end else begin
      fmt_q <= fmt_d;
    end
  end

  // ==========================================
  // Sticky status, mask and interrupt; a set beats a same-cycle clear
  always_comb begin
    ev_set = 8'h00;
    if (seq_done && op_q == ACR_CMD_CONV) begin
      ev_set[`ACR_ST_EOC] = cmd_q[`ACR_CMD_IRQSEL];
      ev_set[`ACR_ST_WIN] = window_hit_in;
    end
    if (seq_done && (op_q == ACR_CMD_OFS || op_q == ACR_CMD_GAIN)) begin
      ev_set[`ACR_ST_CAL] = cmd_q[`ACR_CMD_IRQSEL];
    end
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~wdata_in;
    end
    stat_d = stat_d | ev_set;
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = wdata_in;
    end
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stat_q <= `ACR_RST_IRQ;
      mask_q <= `ACR_RST_IRQ;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  // ==========================================
  // Read data, one cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_d = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `ACR_OFS_CMD: rdata_d = cmd_q;
        `ACR_OFS_FMT: rdata_d = fmt_q;
        `ACR_OFS_STATUS: rdata_d = stat_q;
        `ACR_OFS_MASK: rdata_d = mask_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================
  // Registered control outputs toward the converter core
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_out <= 1'b0;
      command_out <= 2'b00;
      continuous_conversion_out <= 1'b0;
      sample_count_out <= 5'h01;
      cycles_out <= `ACR_CYC_12B;
      scan_enable_out <= 1'b0;
      input_kind_out <= 1'b0;
      result_sign_format_out <= 1'b0;
      result_alignment_out <= 1'b0;
      cal_offset_out <= 1'b0;
      cal_gain_out <= 1'b0;
    end else begin
      busy_out <= seq_busy;
      command_out <= op_q;
      continuous_conversion_out <= cmd_q[`ACR_CMD_CONT];
      sample_count_out <= samples;
      cycles_out <= cycles;
      scan_enable_out <= fmt_q[`ACR_FMT_SCAN];
      input_kind_out <= fmt_q[`ACR_FMT_INKIND];
      result_sign_format_out <= fmt_q[`ACR_FMT_SIGN];
      result_alignment_out <= fmt_q[`ACR_FMT_ALIGN];
      cal_offset_out <= seq_busy && (op_q == ACR_CMD_OFS);
      cal_gain_out <= seq_busy && (op_q == ACR_CMD_GAIN);
    end
  end

  assign rdata_out = rdata_q;
  assign irq_out = irq_q;
endmodule

// ===== verification/acr_control_checker.sv
/*
  Checker for the converter control registers.
  Assumes it is bound to acr_control and sees only its ports.
*/
module acr_control_checker (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic busy_out,
  input wire logic [1:0] command_out,
  input wire logic continuous_conversion_out,
  input wire logic [4:0] sample_count_out,
  input wire logic [4:0] cycles_out,
  input wire logic scan_enable_out,
  input wire logic input_kind_out,
  input wire logic result_sign_format_out,
  input wire logic result_alignment_out,
  input wire logic cal_offset_out,
  input wire logic cal_gain_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Register images and write history
  logic [7:0] cmd_q, cmd_d, fmt_q, fmt_d;
  logic [1:0] wrh_q, wrh_d;
  logic quiet;
  // Next image on every write to either register
  always_comb begin
    cmd_d = cmd_q;
    fmt_d = fmt_q;
    wrh_d = {wrh_q[0], wr_in};
    if (wr_in && addr_in == 12'hF70) cmd_d = wdata_in;
    if (wr_in && addr_in == 12'hF71) fmt_d = wdata_in;
  end
  // Image registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_q <= 8'h00;
      fmt_q <= 8'h00;
      wrh_q <= 2'h0;
    end else begin
      cmd_q <= cmd_d;
      fmt_q <= fmt_d;
      wrh_q <= wrh_d;
    end
  end
  // Outputs have settled once no write happened for three cycles
  assign quiet = !wr_in && wrh_q == 2'h0;
  // ==========================================
  // Assertions
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  AST_RD_SLOT: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside its slot");
  AST_RSV5: assert property (rd_in && addr_in == 12'hF70 |=> rdata_out[5] == 1'b0)
    else $error("command bit 5 not zero");
  AST_FMT: assert property (quiet |-> {scan_enable_out, input_kind_out, result_sign_format_out,
    result_alignment_out} == {fmt_q[5], fmt_q[3], fmt_q[2], fmt_q[0]}) else $error("format copy wrong");
  AST_CNT: assert property (quiet |-> sample_count_out == (cmd_q[2] ? 5'd2 << cmd_q[1:0] : 5'd1)
    && continuous_conversion_out == cmd_q[3]) else $error("sample count wrong");
  AST_CYC: assert property (quiet && !busy_out && !$past(busy_out) && !cal_offset_out && !cal_gain_out
    |-> cycles_out == (fmt_q[1] ? 5'd15 : 5'd13)) else $error("cycle count wrong");
  AST_OFS: assert property (cal_offset_out |-> command_out == 2'b10)
    else $error("offset calibration without its code");
  AST_GAIN: assert property (cal_gain_out |-> command_out == 2'b11)
    else $error("gain calibration without its code");
  AST_IDLE: assert property ($fell(busy_out) && !continuous_conversion_out |-> ##[0:2] command_out == 2'b00)
    else $error("command not back to idle");
endmodule
bind acr_control acr_control_checker u_chk (.clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .busy_out, .command_out, .continuous_conversion_out, .sample_count_out, .cycles_out,
  .scan_enable_out, .input_kind_out, .result_sign_format_out, .result_alignment_out, .cal_offset_out,
  .cal_gain_out);

// ===== verification/acr_control_tb_top.sv
/*
  Self-checking bench for the converter control registers.
  Assumes acr_control and its bound checker are compiled before it.
*/
module acr_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
  typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] r;} acr_row_t;
  typedef struct {logic [7:0] f; logic [7:0] c; int n;} acr_run_t;
  // ==========================================
  // Signals and design
  logic clk_in = 1'b0, reset_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, window_hit_in = 1'b0;
  logic [11:0] addr_in = 12'h000;
  logic [7:0] wdata_in = 8'h00, rdata_out;
  logic irq_out, busy_out, continuous_conversion_out, scan_enable_out, input_kind_out;
  logic result_sign_format_out, result_alignment_out, cal_offset_out, cal_gain_out;
  logic [1:0] command_out;
  logic [4:0] sample_count_out, cycles_out;
  int n_mismatch = 0, checked = 0;
  acr_row_t rows[8] = '{'{12'hF70, 8'h3F, 8'h1F}, '{12'hF70, 8'h1C, 8'h1C}, '{12'hF70, 8'h00, 8'h00},
    '{12'hF71, 8'h2F, 8'h2F}, '{12'hF71, 8'h01, 8'h01}, '{12'hF7B, 8'h07, 8'h07},
    '{12'hF7C, 8'hFF, 8'h00}, '{12'hF6F, 8'hFF, 8'h00}};
  acr_run_t runs[8] = '{'{8'h01, 8'h40, 13}, '{8'h03, 8'h40, 15}, '{8'h01, 8'h44, 26},
    '{8'h01, 8'h45, 52}, '{8'h01, 8'h46, 104}, '{8'h01, 8'h47, 208}, '{8'h01, 8'h90, 16},
    '{8'h01, 8'hD0, 16}};
  acr_control dut (.clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .window_hit_in, .rdata_out,
    .irq_out, .busy_out, .command_out, .continuous_conversion_out, .sample_count_out, .cycles_out,
    .scan_enable_out, .input_kind_out, .result_sign_format_out, .result_alignment_out, .cal_offset_out,
    .cal_gain_out);
  // Clock at 100 MHz
  always #5 clk_in = ~clk_in;
  // ==========================================
  // Bus and timing tasks
  task tick;
    @(posedge clk_in);
    #1;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // Starts an operation and counts its busy cycles
  task run(input logic [7:0] f, input logic [7:0] c, output int n);
    int k;
    wr(12'hF71, f);
    wr(12'hF70, c);
    k = 0;
    n = 0;
    while (busy_out !== 1'b1 && k < 12) begin
      tick;
      k++;
    end
    while (busy_out === 1'b1 && n < 600) begin
      tick;
      n++;
    end
  endtask
  task give_verdict;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100us;
    n_mismatch++;
    give_verdict;
  end
  // ==========================================
  // Main sequence
  initial begin
    logic [7:0] d;
    int n;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(12'hF70 + 12'(i), d);
      `CHK(d, 8'h00)
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      `CHK(d, rows[i].r)
    end
    foreach (runs[i]) begin
      run(runs[i].f, runs[i].c, n);
      `CHK(n, runs[i].n)
      repeat (3) tick;
      rd(12'hF70, d);
      `CHK(d, runs[i].c & 8'h1F)
    end
    wr(12'hF7A, 8'h07);
    repeat (3) tick;
    `CHK(irq_out, 1'b0)
    run(8'h01, 8'h50, n);
    repeat (3) tick;
    `CHK(irq_out, 1'b1)
    rd(12'hF7A, d);
    `CHK(d, 8'h01)
    window_hit_in <= 1'b1;
    run(8'h01, 8'h40, n);
    repeat (3) tick;
    rd(12'hF7A, d);
    `CHK(d, 8'h03)
    window_hit_in <= 1'b0;
    wr(12'hF7B, 8'h00);
    repeat (3) tick;
    `CHK(irq_out, 1'b0)
    wr(12'hF70, 8'h40);
    repeat (4) tick;
    wr(12'hF70, 8'h00);
    repeat (4) tick;
    `CHK(busy_out, 1'b0)
    rd(12'hF70, d);
    `CHK(d, 8'h00)
    give_verdict;
  end
endmodule
